// ===== psr_pkg.sv
// constants, timing counts and codes for the flyback switching control
package psr_pkg;
	// clock
	localparam int CLK_PERIOD_NS      = 50;
	// timing figures in their own units
	localparam int BLANK_NS           = 500;
	// max off wait of 19 ms
	localparam int MAX_OFF_MS         = 19;
	localparam int DELAY_US           = 140;
	localparam int STANDBY_EXTRA_US   = 30;
	localparam int AUDIO_MIN_HZ       = 24000;
	localparam int SEG_UP_HZ          = 50000;
	// derived cycle counts (least times up, longest times down)
	localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_OFF_CYC = (MAX_OFF_MS * 1000000) / CLK_PERIOD_NS;
	localparam int STANDBY_OFF_CYC =
		((DELAY_US + STANDBY_EXTRA_US) * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int AUDIO_CYC = 1000000000 / (AUDIO_MIN_HZ * CLK_PERIOD_NS);
	localparam int SEG_UP_CYC = 1000000000 / (SEG_UP_HZ * CLK_PERIOD_NS);
	// analog comparator thresholds in mV, set outside this logic
	// feedback overvoltage and short levels
	localparam int FB_OVERVOLTAGE_THRESHOLD_MV = 7500;
	localparam int FB_SHORT_THRESHOLD_MV       = 2500;
	localparam int CPC_EXIT_MV                 = 65;
	localparam int CPC_ENTER_MV                = 33;
	localparam int WAKE_PULSE_LEVEL_MV         = 100;
	// counter width and peak threshold codes
	localparam int CNT_W = 20;
	localparam logic [1:0] PEAK_THR_LIGHT  = 2'h0;
	localparam logic [1:0] PEAK_THR_MEDIUM = 2'h1;
	localparam logic [1:0] PEAK_THR_HIGH   = 2'h2;
	// synchronised comparator bit positions
	localparam int NCMP      = 9;
	localparam int C_CS      = 0;
	localparam int C_OVP     = 1;
	localparam int C_SHORT   = 2;
	localparam int C_SAMPLE  = 3;
	localparam int C_CPC_HI  = 4;
	localparam int C_CPC_LO  = 5;
	localparam int C_WAKE    = 6;
	localparam int C_SUP_MIN = 7;
	localparam int C_SUP_ST  = 8;
	typedef enum logic [1:0] {RUN, OVP_WAIT, RESTART} prot_e;
endpackage

// ===== psr_flyback_pfm_control.sv
// switching, standby and protection control of the flyback controller
`timescale 1ns/1ps
module psr_flyback_pfm_control
	import psr_pkg::*;
#(
	parameter int MAX_OFF = MAX_OFF_CYC
)(
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       turn_on_req_i,
	input  wire logic       cc_mode_i,
	input  wire logic       cs_trip_i,
	input  wire logic       fb_ovp_i,
	input  wire logic       fb_short_i,
	input  wire logic       fb_sample_i,
	input  wire logic       cpc_above_exit_i,
	input  wire logic       cpc_below_enter_i,
	input  wire logic       wake_pulse_i,
	input  wire logic       supply_min_i,
	input  wire logic       supply_start_i,
	output logic            gate_o,
	output logic [1:0]      peak_sel_o,
	output logic            standby_light_mode_o,
	output logic            fault_ovp_o,
	output logic            fault_open_o,
	output logic            fault_short_o,
	output logic            restart_o,
	output logic            line_comp_en_o,
	output logic            cable_comp_en_o
);

	typedef struct packed {
		logic [NCMP-1:0]  s1;
		logic [NCMP-1:0]  s2;
		logic [NCMP-1:0]  prev;
		logic             req1;
		logic             req2;
		logic             req_prev;
		prot_e            st;
		logic             gate;
		logic [3:0]       blank;
		logic [CNT_W-1:0] per;
		logic [CNT_W-1:0] off;
		logic [CNT_W-1:0] wait_c;
		logic [CNT_W-1:0] short_c;
		logic [1:0]       seg;
		logic             standby;
		logic             seen_sample;
		logic             f_ovp;
		logic             f_open;
		logic             f_short;
		logic             restart;
	} state_s;

	state_s r;
	state_s next_r;
	logic [NCMP-1:0] cmp_in;
	logic            req_rise;
	logic            wake_rise;
	logic            fire;
	logic            prot_trip;

	assign cmp_in = {supply_start_i, supply_min_i, wake_pulse_i,
		cpc_below_enter_i, cpc_above_exit_i, fb_sample_i, fb_short_i,
		fb_ovp_i, cs_trip_i};
	assign req_rise  = r.req2 & ~r.req_prev;
	assign wake_rise = r.s2[C_WAKE] & ~r.prev[C_WAKE];

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_r = r;
		fire = 1'b0;
		prot_trip = 1'b0;
		next_r.s1 = cmp_in;
		next_r.s2 = r.s1;
		next_r.prev = r.s2;
		next_r.req1 = turn_on_req_i;
		next_r.req2 = r.req1;
		next_r.req_prev = r.req2;
		if (r.per != {CNT_W{1'b1}})
			next_r.per = r.per + 1'b1;
		if (!r.gate && r.off != {CNT_W{1'b1}})
			next_r.off = r.off + 1'b1;
		if (r.s2[C_SAMPLE])
			next_r.seen_sample = 1'b1;
		case (r.st)
			RUN:
			begin
				next_r.restart = 1'b0;
				if (r.s2[C_OVP] && !r.gate)
				begin
					prot_trip = 1'b1;
					next_r.f_ovp = 1'b1;
				end
				// no sample since last pulse is open feedback
				if (!r.standby && req_rise && !r.seen_sample && !r.gate)
				begin
					prot_trip = 1'b1;
					next_r.f_open = 1'b1;
				end
				// short qualified over one max off interval
				if (r.s2[C_SHORT])
					next_r.short_c = r.short_c + 1'b1;
				else
					next_r.short_c = '0;
				if (r.s2[C_SHORT] && r.short_c >= CNT_W'(MAX_OFF - 1))
				begin
					next_r.f_short = 1'b1;
					next_r.restart = 1'b1;
					next_r.gate = 1'b0;
					next_r.standby = 1'b0;
					next_r.st = RESTART;
				end
				else if (prot_trip)
				begin
					// gate low on the trip edge
					next_r.gate = 1'b0;
					next_r.wait_c = '0;
					next_r.standby = 1'b0;
					next_r.st = OVP_WAIT;
				end
				else if (r.gate)
				begin
					// blanking holds gate and masks sense
					if (r.blank != 4'h0)
						next_r.blank = r.blank - 4'h1;
					else if (r.s2[C_CS])
						next_r.gate = 1'b0;
				end
				else if (r.standby)
				begin
					// leave standby on cable comp level
					if (r.s2[C_CPC_HI])
						next_r.standby = 1'b0;
					// wake pulse gives one energy pulse
					if (wake_rise)
					begin
						fire = 1'b1;
						if (r.off < CNT_W'(STANDBY_OFF_CYC))
							next_r.standby = 1'b0;
					end
				end
				else if (req_rise)
				begin
					fire = 1'b1;
					// enter standby on low load signs
					if (r.s2[C_CPC_LO] &&
						r.off >= CNT_W'(STANDBY_OFF_CYC))
						next_r.standby = 1'b1;
					if (cc_mode_i)
						next_r.seg = PEAK_THR_HIGH;
					// long period lowers peak to raise rate
					else if (r.per > CNT_W'(AUDIO_CYC) &&
						r.seg != PEAK_THR_LIGHT)
						next_r.seg = r.seg - 2'h1;
					else if (r.per < CNT_W'(SEG_UP_CYC) &&
						r.seg != PEAK_THR_HIGH)
						next_r.seg = r.seg + 2'h1;
				end
				// standby runs on the light threshold
				if (next_r.standby)
					next_r.seg = PEAK_THR_LIGHT;
				else if (fire && cc_mode_i) // wake exit in cc
					next_r.seg = PEAK_THR_HIGH;
				if (fire)
				begin
					next_r.gate = 1'b1;
					next_r.blank = 4'(BLANK_CYC - 1);
					next_r.per = '0;
					next_r.off = '0;
					next_r.seen_sample = 1'b0;
				end
			end
			OVP_WAIT:
			begin
				next_r.gate = 1'b0;
				next_r.wait_c = r.wait_c + 1'b1;
				if (r.s2[C_SUP_MIN])
				begin
					next_r.restart = 1'b1;
					next_r.st = RESTART;
				end
				// end of wait: resume or wait again
				else if (r.wait_c >= CNT_W'(MAX_OFF - 1))
				begin
					next_r.wait_c = '0;
					if (!r.s2[C_OVP])
					begin
						next_r.st = RUN;
						next_r.f_ovp = 1'b0;
						next_r.f_open = 1'b0;
						next_r.seen_sample = 1'b1;
						next_r.short_c = '0;
					end
				end
			end
			RESTART:
			begin
				next_r.gate = 1'b0;
				// retry at start-up level; overvoltage must clear first, a short need not
				if (r.s2[C_SUP_ST] && (r.f_short || !r.s2[C_OVP]))
				begin
					next_r.st = RUN;
					next_r.restart = 1'b0;
					next_r.f_ovp = 1'b0;
					next_r.f_open = 1'b0;
					next_r.f_short = 1'b0;
					next_r.seen_sample = 1'b1;
					next_r.short_c = '0;
					next_r.seg = PEAK_THR_HIGH;
				end
			end
			default:
			begin
				next_r.st = RESTART;
				next_r.gate = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.st <= RESTART;
			r.restart <= 1'b1;
			r.seg <= PEAK_THR_HIGH;
			r.seen_sample <= 1'b1;
		end
		else
			r <= next_r;
	end

	// outputs straight from state flops; compensation enables decoded from state
	assign gate_o = r.gate;
	assign peak_sel_o = r.seg;
	assign standby_light_mode_o = r.standby;
	assign fault_ovp_o = r.f_ovp;
	assign fault_open_o = r.f_open;
	assign fault_short_o = r.f_short;
	assign restart_o = r.restart;
	assign line_comp_en_o = (r.st == RUN);
	// cable compensation reference lift in RUN outside standby
	assign cable_comp_en_o = (r.st == RUN) & ~r.standby;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_blank_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(r.gate) && r.st == RUN |-> r.gate [*8])
		else $error("gate dropped inside blanking");
	a_prot_gate_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st != RUN |-> !r.gate)
		else $error("gate high while protected");
	a_ovp_trip: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == RUN && r.s2[C_OVP] && !r.gate |=> r.st != RUN)
		else $error("overvoltage not acted on");
	a_cc_high: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == RUN && fire && !next_r.standby && cc_mode_i
		|=> r.seg == PEAK_THR_HIGH)
		else $error("cc mode not on high threshold");
	a_standby_light: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.standby |-> r.seg == PEAK_THR_LIGHT)
		else $error("standby not on light threshold");
	a_cpc_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == RUN && r.standby && !r.gate && r.s2[C_CPC_HI]
		|=> !r.standby)
		else $error("standby kept with cpc high");
	a_wake_fire: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == RUN && r.standby && !r.gate && wake_rise && !prot_trip
		&& !(r.s2[C_SHORT] && r.short_c >= CNT_W'(MAX_OFF - 1))
		|=> r.gate)
		else $error("wake pulse missed");
	a_wait_len: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == OVP_WAIT && r.wait_c < CNT_W'(MAX_OFF - 1)
		&& !r.s2[C_SUP_MIN] |=> r.st == OVP_WAIT)
		else $error("overvoltage wait cut short");
	a_supply_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == OVP_WAIT && r.s2[C_SUP_MIN] |=> r.st == RESTART && r.restart)
		else $error("no restart on low supply");
	a_short_hiccup: assert property (@(posedge mclk_i) disable iff (rst_i)
		r.st == RUN && r.s2[C_SHORT] && r.short_c >= CNT_W'(MAX_OFF - 1)
		|=> r.st == RESTART && r.f_short && !r.gate)
		else $error("short not taken to hiccup");
	a_sync_delay: assert property (@(posedge mclk_i) disable iff (rst_i)
		##2 r.s2[C_OVP] == $past(fb_ovp_i, 2))
		else $error("sync depth wrong");

endmodule // psr_flyback_pfm_control

// ===== psr_stage_model.sv
// model of power switch, sense resistor and secondary monitor
`timescale 1ns/1ps
module psr_stage_model
	import psr_pkg::*;
#(
	parameter int ON_CYC   = 3,
	parameter int WAKE_PER = 600
)(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic gate_i,
	input  wire logic fb_broken_i,
	input  wire logic wake_en_i,
	output logic      cs_trip_o,
	output logic      fb_sample_o,
	output logic      wake_pulse_o
);
	int   on_cnt;
	int   wk_cnt;
	logic gate_q;
	////////////////////////////////////////////////////////////////
	// current ramps while on; a sample follows each turn-off unless fb_broken_i is set
	// monitor pulses at its longest interval
	always_ff @(posedge mclk_i or posedge rst_i)
		if (rst_i)
		begin
			{on_cnt, wk_cnt} <= '0;
			{gate_q, cs_trip_o, fb_sample_o, wake_pulse_o} <= '0;
		end
		else
		begin
			gate_q       <= gate_i;
			on_cnt       <= gate_i ? on_cnt + 1 : 0;
			cs_trip_o    <= gate_i && on_cnt >= ON_CYC; // trips inside blanking
			fb_sample_o  <= gate_q && !gate_i && !fb_broken_i;
			wk_cnt       <= (wake_en_i && wk_cnt < WAKE_PER) ? wk_cnt + 1 : 0;
			wake_pulse_o <= wake_en_i && wk_cnt == WAKE_PER;
		end
endmodule // psr_stage_model

// ===== testbench.sv
// self-checking bench for the flyback switching control
`timescale 1ns/1ps
module testbench;
	import psr_pkg::*;
	localparam int MOFF = 200;
	localparam int WAKE = 600;
	logic       mclk_i, rst_i, turn_on_req_i, cc_mode_i, fb_ovp_i;
	logic       fb_short_i, cpc_above_exit_i, cpc_below_enter_i;
	logic       supply_min_i, supply_start_i, fb_broken, wake_en;
	logic       cs_trip, fb_sample, wake_pulse, gate_o, standby_o;
	logic       f_ovp, f_open, f_short, restart_o, lc_en, cb_en;
	logic [1:0] peak_sel_o;
	int         error_cnt, checked, cyc;
	psr_flyback_pfm_control #(.MAX_OFF(MOFF)) psr_flyback_pfm_control_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .turn_on_req_i(turn_on_req_i),
		.cc_mode_i(cc_mode_i), .cs_trip_i(cs_trip), .fb_ovp_i(fb_ovp_i),
		.fb_short_i(fb_short_i), .fb_sample_i(fb_sample),
		.cpc_above_exit_i(cpc_above_exit_i),
		.cpc_below_enter_i(cpc_below_enter_i), .wake_pulse_i(wake_pulse),
		.supply_min_i(supply_min_i), .supply_start_i(supply_start_i),
		.gate_o(gate_o), .peak_sel_o(peak_sel_o),
		.standby_light_mode_o(standby_o), .fault_ovp_o(f_ovp),
		.fault_open_o(f_open), .fault_short_o(f_short),
		.restart_o(restart_o), .line_comp_en_o(lc_en),
		.cable_comp_en_o(cb_en));
	psr_stage_model #(.WAKE_PER(WAKE)) psr_stage_model_i (
		.mclk_i(mclk_i), .rst_i(rst_i), .gate_i(gate_o),
		.fb_broken_i(fb_broken), .wake_en_i(wake_en),
		.cs_trip_o(cs_trip), .fb_sample_o(fb_sample),
		.wake_pulse_o(wake_pulse));
	////////////////////////////////////////////////////////////////
	// clock and run limit
	initial
	begin
		mclk_i = 0;
		forever #25 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	// compare, wait and pulse tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [1:0] s, input logic [1:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	function automatic logic [1:0] z(input logic x);
		return {1'b0, x};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#5;
	endtask
	// waits, bounded, for gate (sel 0) or restart (sel 1) to reach v
	task automatic await(input bit sel, input logic v, input int n);
		while ((sel ? restart_o : gate_o) !== v && n > 0)
		begin
			tick(1);
			n--;
		end
		chk(z(sel ? restart_o : gate_o), z(v));
	endtask
	// one requested pulse; sense trips early so blanking must hold gate
	task automatic fire();
		turn_on_req_i = 1;
		await(0, 1, 8);
		turn_on_req_i = 0;
		repeat (BLANK_CYC - 1)
		begin
			chk(z(gate_o), 2'h1);
			tick(1);
		end
		await(0, 0, 20);
	endtask
	////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		{turn_on_req_i, cc_mode_i, fb_ovp_i, fb_short_i} = '0;
		{cpc_above_exit_i, cpc_below_enter_i, supply_min_i} = '0;
		{supply_start_i, fb_broken, wake_en} = '0;
		{error_cnt, checked, cyc} = '0;
		rst_i = 1;
		tick(6);
		chk(z(restart_o), 2'h1);
		rst_i = 0;
		supply_start_i = 1;
		await(1, 0, 10);
		chk(z(lc_en), 2'h1);
		chk(z(cb_en), 2'h1);
		cc_mode_i = 1;
		tick(900);
		fire();
		chk(peak_sel_o, PEAK_THR_HIGH);
		cc_mode_i = 0;
		tick(900);
		fire();
		chk(peak_sel_o, PEAK_THR_MEDIUM);
		tick(900);
		fire();
		chk(peak_sel_o, PEAK_THR_LIGHT);
		tick(100);
		fire();
		chk(peak_sel_o, PEAK_THR_MEDIUM);
		// standby entered twice: left on cable comp level, then short off
		cpc_below_enter_i = 1;
		for (int k = 0; k < 2; k++)
		begin
			tick(3500);
			turn_on_req_i = 1;
			tick(5);
			turn_on_req_i = 0;
			tick(25);
			chk(z(standby_o), 2'h1);
			chk(peak_sel_o, PEAK_THR_LIGHT);
			chk(z(cb_en), 2'h0);
			if (k == 0)
			begin
				{cpc_below_enter_i, cpc_above_exit_i} = 2'h1;
				tick(5);
				chk(z(standby_o), 2'h0);
				chk(z(cb_en), 2'h1);
				{cpc_below_enter_i, cpc_above_exit_i} = 2'h2;
			end
		end
		cpc_below_enter_i = 0;
		wake_en = 1;
		await(0, 1, WAKE + 20);
		wake_en = 0;
		await(0, 0, 30);
		chk(z(standby_o), 2'h0);
		// overvoltage wait, repeat wait, resume
		fb_ovp_i = 1;
		tick(4);
		chk(z(f_ovp), 2'h1);
		chk(z(lc_en), 2'h0);
		turn_on_req_i = 1;
		tick(10);
		chk(z(gate_o), 2'h0);
		turn_on_req_i = 0;
		tick(MOFF + 10);
		chk(z(f_ovp), 2'h1);
		fb_ovp_i = 0;
		tick(MOFF + 10);
		chk(z(f_ovp), 2'h0);
		fire();
		// supply collapse during the wait
		fb_ovp_i = 1;
		tick(4);
		supply_min_i = 1;
		supply_start_i = 0;
		tick(5);
		chk(z(restart_o), 2'h1);
		{supply_min_i, fb_ovp_i, supply_start_i} = 3'h1;
		await(1, 0, 10);
		// feedback divider broken
		fb_broken = 1;
		fire();
		turn_on_req_i = 1;
		tick(5);
		chk(z(f_open), 2'h1);
		chk(z(gate_o), 2'h0);
		{turn_on_req_i, fb_broken} = '0;
		tick(MOFF + 10);
		chk(z(f_open), 2'h0);
		// short held one max off interval
		fb_short_i = 1;
		tick(MOFF - 20);
		chk(z(f_short), 2'h0);
		supply_start_i = 0;
		tick(30);
		chk(z(f_short), 2'h1);
		chk(z(restart_o), 2'h1);
		{fb_short_i, supply_start_i} = 2'h1;
		await(1, 0, 10);
		summarize();
	end
endmodule // testbench
